/* File: design/nbps_sequencer.sv */
// Host sequencer that drives buffered programming of a parallel NOR flash.
//
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
module nbps_sequencer #(
	parameter int BUF_DEPTH = nbps_pkg::BUF_DEPTH
) (
	input  wire logic          core_clk,
	input  wire logic          rst_n,
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [7:0]    paddr,
	input  wire logic [31:0]   pwdata,
	output logic [31:0]        prdata,
	output logic               pready,
	output logic               pslverr,
	output nbps_pkg::nbps_pins_t flashOut,
	input  wire logic [15:0]   dqIn
);
	localparam int IW = nbps_pkg::IDX_W;
	localparam int AW = $clog2(BUF_DEPTH);
	localparam int AD = nbps_pkg::ADDR_W; // Flash word address width.

	////////////////////////////////////////////////////////////////////////
	// State and register declarations.
	nbps_pkg::nbps_state_t state, next_state; // Sequencer state.
	logic [7:0]    timer, next_timer;       // Pin timing down-counter.
	logic [IW-1:0] step, next_step;         // Index of the bus write.
	logic [3:0]    op, next_op;             // Operation being run.
	logic          bypass, next_bypass;     // Device in bypass mode.
	logic          susp, next_susp;         // Program is suspended.
	logic          done, next_done;         // Last operation finished.
	logic          aborted, next_aborted;   // Device reported abort.
	logic          failed, next_failed;     // Device reported failure.
	logic          refused, next_refused;   // Request not issued.
	logic          polling, next_polling;   // Status polling active.
	logic          firstRd, next_firstRd;   // First status read.
	logic          failSeen, next_failSeen; // Failure flag once seen.
	logic [15:0]   prevStat, next_prevStat; // Previous status word.
	logic [15:0]   rdata, next_rdata;       // Last word read.
	logic [25:0]   regAddr, next_regAddr;   // Start address.
	logic [8:0]    regCount, next_regCount; // Count n.
	logic [IW-1:0] wptr, next_wptr;         // Words loaded so far.
	nbps_pkg::nbps_pins_t next_flashOut;    // Next pin values.
	logic [31:0]   next_prdata;             // Next read data.
	logic          next_pready;             // Next ready.
	logic          next_pslverr;            // Next error.
	logic [15:0]   bufMem [BUF_DEPTH];      // Words to be programmed.
	logic [15:0]   dqS1, dqS2, dqS3;        // Data pin synchroniser.

	// Helper signals.
	logic          access;   // APB access cycle awaiting answer.
	logic          go;       // Control write accepted.
	logic          bufLoad;  // Data word accepted into the buffer.
	logic          crossing; // Requested run leaves its page.
	logic          shortBuf; // Too few words loaded, or too many asked.
	logic [3:0]    reqOp;    // Requested operation.
	logic [IW-1:0] bufIdx;   // Buffer word for the current step.
	nbps_pkg::nbps_step_t cur; // Current bus write.

	////////////////////////////////////////////////////////////////////////
	// Number of unlock writes that precede a program setup.
	function automatic logic [IW-1:0] unlockLen(input logic byp);
		return byp ? '0 : IW'(2);
	endfunction : unlockLen

	// Pin values that open a read cycle at an address.
	function automatic nbps_pkg::nbps_pins_t readPins(
		input logic [25:0] a);
		nbps_pkg::nbps_pins_t p;
		p = nbps_pkg::PINS_IDLE;
		p.ceN = 1'b0;
		p.oeN = 1'b0;
		p.addr = a;
		return p;
	endfunction : readPins

	// Address, data and end mark of bus write k of operation o.
	function automatic nbps_pkg::nbps_step_t stepOf(
		input logic [3:0] o, input logic [IW-1:0] k,
		input logic byp, input logic [25:0] a,
		input logic [8:0] n, input logic [15:0] w);
		nbps_pkg::nbps_step_t s;
		logic [IW-1:0] u;
		u = unlockLen(byp);
		s.addr = a;
		s.data = w;
		s.last = 1'b0;
		case (o)
			nbps_pkg::OP_ENTER, nbps_pkg::OP_ABORT: begin
				// Both take the full three writes, bypass or not.
				s.addr = (k == IW'(1)) ? nbps_pkg::UNL_ADDR2
					: nbps_pkg::UNL_ADDR1;
				s.data = (k == '0) ? nbps_pkg::C_UNL1
					: (k == IW'(1)) ? nbps_pkg::C_UNL2
					: (o == nbps_pkg::OP_ENTER) ? nbps_pkg::C_ENTER
					: nbps_pkg::C_RESET;
				s.last = (k == IW'(2));
			end
			nbps_pkg::OP_EXIT: begin
				s.data = (k == '0) ? nbps_pkg::C_EXIT1
					: nbps_pkg::C_EXIT2;
				s.last = (k != '0);
			end
			nbps_pkg::OP_WORD, nbps_pkg::OP_BUF: begin
				if (k < u) begin
					// Unlocks are skipped in bypass mode.
					s.addr = (k == '0) ? nbps_pkg::UNL_ADDR1
						: nbps_pkg::UNL_ADDR2;
					s.data = (k == '0) ? nbps_pkg::C_UNL1
						: nbps_pkg::C_UNL2;
				end else if (k == u) begin
					// Setup goes to the target block.
					s.data = (o == nbps_pkg::OP_WORD) ? nbps_pkg::C_WORD
						: nbps_pkg::C_BUF;
				end else if (o == nbps_pkg::OP_WORD) begin
					s.last = 1'b1;
				end else if (k == u + IW'(1)) begin
					s.data = 16'(n);
				end else if (k <= u + {1'b0, n} + IW'(2)) begin
					// Start word, then n more in ascending order.
					s.addr = a + AD'(k - u - IW'(2));
				end else begin
					s.data = nbps_pkg::C_CONFIRM;
					s.last = 1'b1;
				end
			end
			default: begin
				s.data = (o == nbps_pkg::OP_RESET) ? nbps_pkg::C_RESET
					: (o == nbps_pkg::OP_SUSPEND) ? nbps_pkg::C_SUSPEND
					: nbps_pkg::C_RESUME;
				s.last = 1'b1;
			end
		endcase
		return s;
	endfunction : stepOf

	////////////////////////////////////////////////////////////////////////
	// Decode of the APB access and of the current write.
	assign access = psel & penable & ~pready;
	assign reqOp = pwdata[3:0];
	// A suspend may cut into status polling; all else waits for idle.
	assign go = access & pwrite & (paddr == nbps_pkg::REG_CTRL)
		& ((state == nbps_pkg::S_IDLE) | (polling
		& (state == nbps_pkg::S_RGAP)
		& (reqOp == nbps_pkg::OP_SUSPEND)));
	assign bufLoad = access & pwrite & (paddr == nbps_pkg::REG_DATA)
		& (wptr < IW'(BUF_DEPTH));
	// The run must stay in the start page; refuse rather than abort.
	assign crossing = ({1'b0, regAddr[8:0]} + {1'b0, regCount})
		> {1'b0, 9'h1FF};
	// Asking for more than the buffer holds would abort the device.
	assign shortBuf = (wptr <= {1'b0, regCount})
		| ({1'b0, regCount} >= IW'(BUF_DEPTH));
	assign bufIdx = (op == nbps_pkg::OP_WORD) ? '0
		: step - unlockLen(bypass) - IW'(2);
	assign cur = stepOf(op, step, bypass, regAddr, regCount,
		bufMem[bufIdx[AW-1:0]]);

	////////////////////////////////////////////////////////////////////////
	// Next-state logic for the register file and the pin sequencer.
	always_comb begin
		logic [15:0] val;
		logic [31:0] sr;
		val = dqS3;
		sr = '0;
		next_state = state;
		next_timer = timer;
		next_step = step;
		next_op = op;
		next_bypass = bypass;
		next_susp = susp;
		next_done = done;
		next_aborted = aborted;
		next_failed = failed;
		next_refused = refused;
		next_polling = polling;
		next_firstRd = firstRd;
		next_failSeen = failSeen;
		next_prevStat = prevStat;
		next_rdata = rdata;
		next_regAddr = regAddr;
		next_regCount = regCount;
		next_wptr = wptr;
		next_flashOut = flashOut;
		next_prdata = prdata;
		next_pready = 1'b0;
		next_pslverr = 1'b0;
		sr[nbps_pkg::SR_BUSY] = (state != nbps_pkg::S_IDLE);
		sr[nbps_pkg::SR_DONE] = done;
		sr[nbps_pkg::SR_ABORTED] = aborted;
		sr[nbps_pkg::SR_FAILED] = failed;
		sr[nbps_pkg::SR_REFUSED] = refused;
		sr[nbps_pkg::SR_SUSP] = susp;
		sr[nbps_pkg::SR_BYPASS] = bypass;
		// Register access: one wait state, then a one-cycle ready.
		if (access) begin
			next_pready = 1'b1;
			if (pwrite) begin
				case (paddr)
					nbps_pkg::REG_CTRL: next_pslverr = ~go;
					nbps_pkg::REG_ADDR: next_regAddr = pwdata[25:0];
					nbps_pkg::REG_COUNT: next_regCount = pwdata[8:0];
					nbps_pkg::REG_DATA: begin
						// A word beyond the buffer is refused.
						next_pslverr = ~bufLoad;
						if (bufLoad) begin
							next_wptr = wptr + IW'(1);
						end
					end
					default: next_pslverr = 1'b1;
				endcase
			end else begin
				case (paddr)
					nbps_pkg::REG_ADDR: next_prdata = 32'(regAddr);
					nbps_pkg::REG_COUNT: next_prdata = 32'(regCount);
					nbps_pkg::REG_DATA: next_prdata = 32'(wptr);
					nbps_pkg::REG_STATUS: next_prdata = sr;
					nbps_pkg::REG_RDATA: next_prdata = 32'(rdata);
					default: begin
						next_prdata = '0;
						next_pslverr = 1'b1;
					end
				endcase
			end
		end
		unique case (state)
			nbps_pkg::S_IDLE: begin
				if (go) begin
					next_op = reqOp;
					next_done = 1'b0;
					next_refused = 1'b0;
					next_step = '0;
					if (reqOp == nbps_pkg::OP_READ) begin
						next_polling = 1'b0;
						next_flashOut = readPins(regAddr);
						next_timer = 8'(nbps_pkg::ACC_CYC
							+ nbps_pkg::SYNC_CYC - 1);
						next_state = nbps_pkg::S_RLOW;
					end else if ((reqOp == nbps_pkg::OP_BUF)
						&& (crossing || shortBuf)) begin
						next_refused = 1'b1;
						next_done = 1'b1;
					end else begin
						next_state = nbps_pkg::S_WSET;
					end
				end
			end
			nbps_pkg::S_WSET: begin
				// Present address and data with both strobes low.
				next_flashOut = nbps_pkg::PINS_IDLE;
				next_flashOut.ceN = 1'b0;
				next_flashOut.weN = 1'b0;
				next_flashOut.dqOe = 1'b1;
				next_flashOut.addr = cur.addr;
				next_flashOut.dqOut = cur.data;
				next_timer = 8'(nbps_pkg::WP_CYC - 1);
				next_state = nbps_pkg::S_WLOW;
			end
			nbps_pkg::S_WLOW: begin
				if (timer != '0) begin
					next_timer = timer - 8'h01;
				end else begin
					// Rising strobe latches; data held through high.
					next_flashOut.weN = 1'b1;
					next_flashOut.ceN = 1'b1;
					next_timer = 8'(nbps_pkg::WPH_CYC - 1);
					next_state = nbps_pkg::S_WHIGH;
				end
			end
			nbps_pkg::S_WHIGH: begin
				if (timer != '0) begin
					next_timer = timer - 8'h01;
				end else begin
					next_flashOut.dqOe = 1'b0;
					next_state = nbps_pkg::S_IDLE;
					next_done = 1'b1;
					if (!cur.last) begin
						next_step = step + IW'(1);
						next_state = nbps_pkg::S_WSET;
						next_done = 1'b0;
					end else begin
						case (op)
							nbps_pkg::OP_ENTER: next_bypass = 1'b1;
							nbps_pkg::OP_EXIT: next_bypass = 1'b0;
							nbps_pkg::OP_ABORT: next_aborted = 1'b0;
							nbps_pkg::OP_RESET: next_failed = 1'b0;
							nbps_pkg::OP_SUSPEND: next_susp = 1'b1;
							default: begin
								// Program or resume: poll status.
								next_susp = 1'b0;
								next_done = 1'b0;
								next_polling = 1'b1;
								next_firstRd = 1'b1;
								next_failSeen = 1'b0;
								if (op != nbps_pkg::OP_RESUME) begin
									next_wptr = '0;
								end
								next_flashOut = readPins(regAddr);
								next_timer = 8'(nbps_pkg::ACC_CYC
									+ nbps_pkg::SYNC_CYC - 1);
								next_state = nbps_pkg::S_RLOW;
							end
						endcase
					end
				end
			end
			nbps_pkg::S_RLOW: begin
				if (timer != '0) begin
					next_timer = timer - 8'h01;
				end else if (dqS2 == dqS3) begin
					// Data settled in the synchroniser: take it.
					next_flashOut.ceN = 1'b1;
					next_flashOut.oeN = 1'b1;
					next_timer = 8'(nbps_pkg::WPH_CYC - 1);
					next_state = nbps_pkg::S_RGAP;
					next_prevStat = val;
					next_firstRd = 1'b0;
					if (!polling) begin
						next_rdata = val;
						next_done = 1'b1;
					end else if (!firstRd) begin
						next_rdata = val;
						if (val[nbps_pkg::ST_TOGGLE]
							== prevStat[nbps_pkg::ST_TOGGLE]) begin
							// Toggle stopped: finished or ignored.
							next_polling = 1'b0;
							next_done = 1'b1;
						end else if (val[nbps_pkg::ST_ABORT]) begin
							next_aborted = 1'b1;
							next_polling = 1'b0;
							next_done = 1'b1;
						end else if (val[nbps_pkg::ST_FAIL]) begin
							// Reread once: polling moves with failure.
							next_failSeen = 1'b1;
							if (failSeen) begin
								next_failed = 1'b1;
								next_polling = 1'b0;
								next_done = 1'b1;
							end
						end
					end
				end
			end
			nbps_pkg::S_RGAP: begin
				if (go) begin
					// Suspend cuts into polling of a program.
					next_op = reqOp;
					next_polling = 1'b0;
					next_step = '0;
					next_state = nbps_pkg::S_WSET;
				end else if (timer != '0) begin
					next_timer = timer - 8'h01;
				end else if (polling) begin
					next_flashOut = readPins(regAddr);
					next_timer = 8'(nbps_pkg::ACC_CYC
						+ nbps_pkg::SYNC_CYC - 1);
					next_state = nbps_pkg::S_RLOW;
				end else begin
					next_state = nbps_pkg::S_IDLE;
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Registers of the sequencer and the bus slave.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state <= nbps_pkg::S_IDLE;
			timer <= '0;
			step <= '0;
			op <= nbps_pkg::OP_READ;
			bypass <= 1'b0;
			susp <= 1'b0;
			done <= 1'b0;
			aborted <= 1'b0;
			failed <= 1'b0;
			refused <= 1'b0;
			polling <= 1'b0;
			firstRd <= 1'b0;
			failSeen <= 1'b0;
			prevStat <= '0;
			rdata <= '0;
			regAddr <= '0;
			regCount <= '0;
			wptr <= '0;
			flashOut <= nbps_pkg::PINS_IDLE;
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			state <= next_state;
			timer <= next_timer;
			step <= next_step;
			op <= next_op;
			bypass <= next_bypass;
			susp <= next_susp;
			done <= next_done;
			aborted <= next_aborted;
			failed <= next_failed;
			refused <= next_refused;
			polling <= next_polling;
			firstRd <= next_firstRd;
			failSeen <= next_failSeen;
			prevStat <= next_prevStat;
			rdata <= next_rdata;
			regAddr <= next_regAddr;
			regCount <= next_regCount;
			wptr <= next_wptr;
			flashOut <= next_flashOut;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// Buffer words and the three-stage data pin synchroniser.
	always_ff @(posedge core_clk) begin
		if (bufLoad) begin
			bufMem[wptr[AW-1:0]] <= pwdata[15:0];
		end
		dqS1 <= dqIn;
		dqS2 <= dqS1;
		dqS3 <= dqS2;
	end

	////////////////////////////////////////////////////////////////////////
	// Checks on the pin sequences, the status flags and the bus ready.
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	sequence s_weLow;
		!flashOut.weN [*7] ##1 flashOut.weN;
	endsequence

	a_we_width: assert property ($fell(flashOut.weN) |-> s_weLow)
		else $error("write strobe width wrong");
	a_ce_with_we: assert property (!flashOut.weN
		|-> !flashOut.ceN && flashOut.dqOe && flashOut.oeN)
		else $error("write strobe without chip enable");
	a_oe_no_drive: assert property (!flashOut.oeN
		|-> !flashOut.dqOe && flashOut.weN)
		else $error("driving data during a read");
	a_confirm_code: assert property ((state == nbps_pkg::S_WHIGH)
		&& (op == nbps_pkg::OP_BUF) && cur.last
		|-> flashOut.dqOut == nbps_pkg::C_CONFIRM)
		else $error("buffer run not closed by confirm");
	a_bypass_setup: assert property ((state == nbps_pkg::S_WSET)
		&& (op == nbps_pkg::OP_BUF) && bypass && (step == '0)
		|=> flashOut.dqOut == nbps_pkg::C_BUF)
		else $error("bypass buffer run starts with unlock");
	a_abort_three: assert property ((state == nbps_pkg::S_WHIGH)
		&& (op == nbps_pkg::OP_ABORT) && cur.last
		|-> step == IW'(2) && flashOut.dqOut == nbps_pkg::C_RESET)
		else $error("abort and reset not three writes");
	a_exit_pair: assert property ((state == nbps_pkg::S_WSET)
		&& (op == nbps_pkg::OP_EXIT) && (step == IW'(1))
		|=> flashOut.dqOut == nbps_pkg::C_EXIT2)
		else $error("bypass exit second code wrong");
	a_page_refuse: assert property (go && (reqOp == nbps_pkg::OP_BUF)
		&& crossing |=> refused && (state == nbps_pkg::S_IDLE))
		else $error("page crossing run was issued");
	a_enter_mode: assert property ((state == nbps_pkg::S_WHIGH)
		&& (timer == '0) && (op == nbps_pkg::OP_ENTER)
		&& cur.last |=> bypass ##1 bypass)
		else $error("bypass mode not recorded");
	a_poll_done: assert property ((state == nbps_pkg::S_RLOW)
		&& polling && !firstRd && (timer == '0) && (dqS2 == dqS3)
		&& (dqS3[nbps_pkg::ST_TOGGLE] == prevStat[nbps_pkg::ST_TOGGLE])
		|=> done && !polling)
		else $error("steady toggle did not end polling");
	a_pready_pulse: assert property ($rose(pready) |=> !pready)
		else $error("ready longer than one cycle");
endmodule : nbps_sequencer

/* File: design/nbps_pkg.sv */
// Constants and carrier types for the buffered program sequencer host.
package nbps_pkg;
	localparam int ADDR_W = 26; // Flash word address width.
	localparam int DATA_W = 16; // Word-wide flash data bus.
	localparam int BUF_DEPTH = 512; // Program buffer words.
	localparam int CNT_W = 9; // Width of the count n.
	localparam int IDX_W = 10; // Width of the step index.
	localparam int CLK_MHZ = 200; // Core clock rate.
	localparam int T_WP_NS = 35; // Least write-enable low time.
	localparam int T_WPH_NS = 30; // Least write-enable high time.
	localparam int T_ACC_NS = 100; // Least read access time.
	localparam int WP_CYC = (T_WP_NS * CLK_MHZ + 999) / 1000;
	localparam int WPH_CYC = (T_WPH_NS * CLK_MHZ + 999) / 1000;
	localparam int ACC_CYC = (T_ACC_NS * CLK_MHZ + 999) / 1000;
	localparam int SYNC_CYC = 3; // Pin synchroniser depth.
	localparam logic [ADDR_W-1:0] UNL_ADDR1 = 26'h0000555;
	localparam logic [ADDR_W-1:0] UNL_ADDR2 = 26'h00002AA;
	localparam logic [DATA_W-1:0] C_UNL1 = 16'h00AA;
	localparam logic [DATA_W-1:0] C_UNL2 = 16'h0055;
	localparam logic [DATA_W-1:0] C_ENTER = 16'h0020;
	localparam logic [DATA_W-1:0] C_EXIT1 = 16'h0090;
	localparam logic [DATA_W-1:0] C_EXIT2 = 16'h0000;
	localparam logic [DATA_W-1:0] C_WORD = 16'h00A0;
	localparam logic [DATA_W-1:0] C_BUF = 16'h0025;
	localparam logic [DATA_W-1:0] C_CONFIRM = 16'h0029;
	localparam logic [DATA_W-1:0] C_RESET = 16'h00F0;
	localparam logic [DATA_W-1:0] C_SUSPEND = 16'h00B0;
	localparam logic [DATA_W-1:0] C_RESUME = 16'h0030;
	localparam logic [3:0] OP_READ = 4'h0, OP_ENTER = 4'h1;
	localparam logic [3:0] OP_EXIT = 4'h2, OP_WORD = 4'h3;
	localparam logic [3:0] OP_BUF = 4'h4, OP_ABORT = 4'h5;
	localparam logic [3:0] OP_RESET = 4'h6, OP_SUSPEND = 4'h7;
	localparam logic [3:0] OP_RESUME = 4'h8;
	localparam logic [7:0] REG_CTRL = 8'h00, REG_ADDR = 8'h04;
	localparam logic [7:0] REG_COUNT = 8'h08, REG_DATA = 8'h0C;
	localparam logic [7:0] REG_STATUS = 8'h10, REG_RDATA = 8'h14;
	localparam int ST_ABORT = 1, ST_FAIL = 5, ST_TOGGLE = 6;
	localparam int SR_BUSY = 0, SR_DONE = 1, SR_ABORTED = 2;
	localparam int SR_FAILED = 3, SR_REFUSED = 4, SR_SUSP = 5;
	localparam int SR_BYPASS = 6;
	typedef enum logic [5:0] {
		S_IDLE = 6'h01, S_WSET = 6'h02, S_WLOW = 6'h04,
		S_WHIGH = 6'h08, S_RLOW = 6'h10, S_RGAP = 6'h20
	} nbps_state_t;
	typedef struct packed {
		logic ceN; logic oeN; logic weN; logic dqOe;
		logic [ADDR_W-1:0] addr; logic [DATA_W-1:0] dqOut;
	} nbps_pins_t;
	typedef struct packed {
		logic [ADDR_W-1:0] addr; logic [DATA_W-1:0] data;
		logic last;
	} nbps_step_t;
	localparam nbps_pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b1,
		1'b0, 26'h0000000, 16'h0000};
endpackage : nbps_pkg

/* File: test/nbps_flash_model.sv */
// Behavioural flash device that answers the sequencer's bus cycles.
`timescale 1ns/1ps
module nbps_flash_model (
	input  wire logic        ceN,
	input  wire logic        oeN,
	input  wire logic        weN,
	input  wire logic [25:0] addr,
	input  wire logic [15:0] dqOut,
	output logic      [15:0] dqDrv
);
	logic [15:0] mem [int], pend [int], w, rd, last; // Array and buffer.
	logic [25:0] blk, base; // Selected block and start address.
	logic        byp, ab, tog, susp; // Mode flags.
	int          st, cnt, busy; // Decoder step, loads left, busy reads.
	initial {byp, ab, tog, susp, st, busy, rd, last} = 0;
	////////////////////////////////////////////////////////////////
	// Programming only clears bits; erased words read as all ones.
	// The top block is protected: a program there is silently dropped.
	task automatic prog(input int a, input logic [15:0] d);
		if (a[25:16] == 10'h3FF) return;
		mem[a] = (mem.exists(a) ? mem[a] : 16'hFFFF) & d;
		busy = 4;
	endtask : prog
	// Command decoder, latched on the rising write strobe.
	always @(posedge weN) begin
		w = dqOut;
		if (busy > 0) begin
			if (w == 16'h00B0) susp = 1'b1;
			if (w == 16'h0030) susp = 1'b0;
		end else if (st == 1) st = (w == 16'h0055) ? 2 : 0;
		else if (st == 2 || (st == 0 && byp && !ab && w != 16'h00AA)) begin
			if (w == 16'h0020) byp = 1'b1;
			if (w == 16'h00F0) ab = 1'b0;
			blk = addr;
			st = ab ? 0 : (w == 16'h00A0) ? 3 : (w == 16'h0025) ? 4 : 0;
			if (w == 16'h0090 && byp) st = 7;
		end else if (st == 0) st = (w == 16'h00AA) ? 1 : 0;
		else if (st == 3) begin
			last = w;
			prog(addr, w);
			st = 0;
		end else if (st == 4) begin
			cnt = w + 1;
			st = (cnt > 512) ? 9 : 5;
		end else if (st == 5 || st == 6) begin
			if (st == 5) base = addr;
			last = w;
			pend[addr] = w;
			cnt--;
			st = (cnt == 0) ? 8 : 6;
			if (addr[25:16] != blk[25:16] || addr[25:9] != base[25:9])
				st = 9;
		end else if (st == 8) begin
			if (w == 16'h0029) foreach (pend[i]) prog(i, pend[i]);
			pend.delete();
			st = (w == 16'h0029) ? 0 : 9;
		end else begin
			if (w == 16'h0000) byp = 1'b0;
			st = 0;
		end
		if (st == 9) begin
			ab = 1'b1;
			st = 0;
		end
	end
	// Status replaces array data while busy and not suspended, or while aborted.
	always @(negedge oeN) begin
		#1; // The address launches with the strobe; let it settle first.
		if ((busy > 0 && !susp) || ab) begin
			tog = ~tog;
			rd = {8'h00, ~last[7], tog, 4'h0, ab, 1'b0};
			if (!ab) busy--;
		end else rd = mem.exists(addr) ? mem[addr] : 16'hFFFF;
	end
	// A released bus shows the inverse of the last word, never a copy.
	assign dqDrv = (!oeN && !ceN) ? rd : ~rd;
endmodule : nbps_flash_model

/* File: test/nor_buffered_program_sequencer_test.sv */
// Self-checking bench for the buffered program sequencer host.
`timescale 1ns/1ps
module nor_buffered_program_sequencer_test;
	logic        core_clk, rst_n, psel, penable, pwrite, pready, pslverr, e;
	logic [7:0]  paddr; // Register offset.
	logic [31:0] pwdata, prdata, r; // Bus data and last read.
	logic [15:0] dqIn, dqDrv, refWord [int]; // Wire and expected array.
	logic [25:0] s; // Start address under test.
	int          n_fail, n_tests, seed, k, n;
	nbps_pkg::nbps_pins_t pins; // Flash pins from the host.
	// The host wins the data wire only while it enables its drivers.
	assign dqIn = pins.dqOe ? pins.dqOut : dqDrv;
	nbps_sequencer #(.BUF_DEPTH(512)) u_dut (.core_clk(core_clk),
		.rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .flashOut(pins), .dqIn(dqIn));
	nbps_flash_model u_flash (.ceN(pins.ceN), .oeN(pins.oeN),
		.weN(pins.weN), .addr(pins.addr), .dqOut(pins.dqOut), .dqDrv(dqDrv));
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	////////////////////////////////////////////////////////////////
	function automatic logic [15:0] expw(input int x, input logic [15:0] d);
		return (refWord.exists(x) ? refWord[x] : 16'hFFFF) & d;
	endfunction : expw
	function automatic logic fits(input logic [25:0] a, input int c);
		return (int'(a[8:0]) + c) <= 511;
	endfunction : fits
	task automatic chk(input logic ok, input string m);
		n_tests++;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask : chk
	// One transfer; the request stands until pready is seen high.
	task automatic apb(input logic w, input logic [7:0] a, input int d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask : apb
	// Start an operation and poll status until it reports done.
	task automatic op(input int o);
		apb(1'b1, nbps_pkg::REG_CTRL, o);
		k = 0;
		do begin
			apb(1'b0, nbps_pkg::REG_STATUS, 0);
			k++;
		end while (r[nbps_pkg::SR_DONE] !== 1'b1 && k < 4000);
		chk(k < 4000, "operation never finished");
	endtask : op
	task automatic rb(input int x);
		apb(1'b1, nbps_pkg::REG_ADDR, x);
		op(0);
		apb(1'b0, nbps_pkg::REG_RDATA, 0);
		chk(r[15:0] === expw(x, 16'hFFFF), "array readback");
	endtask : rb
	// Data keeps status bits 1 and 5 low so polling never misreads it.
	task automatic bprog(input logic [25:0] a, input int c);
		logic [15:0] d;
		apb(1'b1, nbps_pkg::REG_ADDR, int'(a));
		apb(1'b1, nbps_pkg::REG_COUNT, c);
		for (int i = 0; i <= c; i++) begin
			d = 16'($random(seed)) & 16'hFFDD;
			apb(1'b1, nbps_pkg::REG_DATA, int'(d));
			if (fits(a, c)) refWord[a + i] = expw(a + i, d);
		end
		op(4);
		chk(r[nbps_pkg::SR_REFUSED] === !fits(a, c), "refused flag");
		for (int i = 0; i <= c && fits(a, c); i++) rb(a + i);
	endtask : bprog
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_of_test
	initial begin
		#(5 * 90000);
		n_fail++;
		end_of_test();
	end
	////////////////////////////////////////////////////////////////
	initial begin
		{psel, penable, pwrite, paddr, pwdata, rst_n} = 0;
		{seed, n_fail, n_tests} = {32'd40, 64'd0};
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		apb(1'b0, nbps_pkg::REG_STATUS, 0);
		chk(r === 32'h00000000, "status after reset");
		apb(1'b0, 8'h20, 0);
		chk(e === 1'b1, "unmapped offset accepted");
		$display("test reset done");
		for (int t = 0; t < 5; t++) begin
			s = 26'($random(seed)) & 26'h1FFFEFF; // Fits, unprotected.
			n = {$random(seed)} % 8;
			if (t == 0) s[8:0] = 9'h1FF - 9'(n); // Ends on the page's last word.
			if (t == 1) s[8:0] = 9'h000;
			if (t == 4) s = 26'h0000000; // Start of the first page.
			bprog(s, n);
		end
		$display("test buffered done");
		op(1);
		chk(r[nbps_pkg::SR_BYPASS] === 1'b1, "bypass entry");
		bprog(26'($random(seed)) & 26'h1FFFEFF, 3);
		apb(1'b1, nbps_pkg::REG_ADDR, 32'h00000140);
		apb(1'b1, nbps_pkg::REG_DATA, 32'h00005A0C);
		refWord[32'h140] = expw(32'h140, 16'h5A0C);
		op(3);
		rb(32'h140);
		op(2);
		chk(r[nbps_pkg::SR_BYPASS] === 1'b0, "bypass exit");
		rb(32'h140);
		$display("test bypass done");
		op(5);
		chk(r[nbps_pkg::SR_ABORTED] === 1'b0, "abort reset");
		op(6);
		chk(r[nbps_pkg::SR_FAILED] === 1'b0, "plain reset");
		op(7);
		chk(r[nbps_pkg::SR_SUSP] === 1'b1, "suspend flag");
		op(8);
		chk(r[nbps_pkg::SR_SUSP] === 1'b0, "resume flag");
		$display("test recovery done");
		apb(1'b1, nbps_pkg::REG_ADDR, 32'h00000150);
		apb(1'b1, nbps_pkg::REG_DATA, 32'h00001208);
		refWord[32'h150] = expw(32'h150, 16'h1208);
		apb(1'b1, nbps_pkg::REG_CTRL, 3);
		chk(e === 1'b0, "word program refused");
		k = 0;
		do begin
			apb(1'b1, nbps_pkg::REG_CTRL, 7);
			k++;
		end while (e === 1'b1 && k < 200);
		chk(e === 1'b0, "suspend never taken");
		do apb(1'b0, nbps_pkg::REG_STATUS, 0);
		while (r[nbps_pkg::SR_DONE] !== 1'b1);
		chk(r[nbps_pkg::SR_SUSP] === 1'b1, "suspend in program");
		rb(32'h140);
		op(8);
		chk(r[nbps_pkg::SR_SUSP] === 1'b0, "resume in program");
		rb(32'h150);
		apb(1'b1, nbps_pkg::REG_ADDR, 32'h03FF0010);
		apb(1'b1, nbps_pkg::REG_DATA, 32'h00000000);
		op(3);
		rb(32'h03FF0010);
		$display("test suspend done");
		bprog(26'h00001FE, 5);
		apb(1'b1, nbps_pkg::REG_COUNT, 511);
		op(4);
		chk(r[nbps_pkg::SR_REFUSED] === 1'b1, "short load accepted");
		$display("test refusal done");
		end_of_test();
	end
endmodule : nor_buffered_program_sequencer_test
